// >>> gpm_port.v
// Eight-pin GPIO port with address-masked data access, interrupts and pad settings
`timescale 1ns/1ps
module gpm_port #(
	parameter WIDTH     = 8,
	parameter AF_RESET  = 8'h00
) (
	// Clock and reset
	input  wire             clk,
	input  wire             rst_n,
	// Register bus
	input  wire [11:0]      addr,
	input  wire [31:0]      wdata,
	input  wire             wr,
	input  wire             rd,
	output reg  [31:0]      rdata,
	// Pads
	input  wire [WIDTH-1:0] pin_in,
	output reg  [WIDTH-1:0] pin_out,
	output reg  [WIDTH-1:0] pin_oe,
	// Alternate function peripherals
	input  wire [WIDTH-1:0] alt_out,
	input  wire [WIDTH-1:0] alt_oe,
	output wire [WIDTH-1:0] alt_in,
	// Pad configuration
	output reg  [WIDTH-1:0] drive_low_select,
	output reg  [WIDTH-1:0] drive_mid_select,
	output reg  [WIDTH-1:0] drive_high_select,
	output reg  [WIDTH-1:0] open_drain_enable,
	output reg  [WIDTH-1:0] pull_up_enable,
	output reg  [WIDTH-1:0] pull_down_enable,
	output reg  [WIDTH-1:0] slew_limit_enable,
	output reg  [WIDTH-1:0] digital_input_enable,
	// Interrupt
	output reg              irq
);
`include "gpm_map.vh"

	reg  [WIDTH-1:0] pin_direction;
	reg  [WIDTH-1:0] port_value;
	reg  [WIDTH-1:0] alt_function_select;
	reg  [WIDTH-1:0] irq_sense_select;
	reg  [WIDTH-1:0] irq_dual_edge;
	reg  [WIDTH-1:0] irq_event_polarity;
	reg  [WIDTH-1:0] irq_enable_mask;
	wire [WIDTH-1:0] irq_raw_status;
	wire [WIDTH-1:0] irq_masked_status;
	wire [WIDTH-1:0] pin_sync;
	wire [WIDTH-1:0] addr_mask;
	wire [WIDTH-1:0] clear_bits;
	wire             data_hit;
	reg  [31:0]      next_rdata;

	// ==========================================================
	// Address decode
	assign data_hit  = (addr[`GPM_DATA_SEL_HI:`GPM_DATA_SEL_LO] == `GPM_DATA_SEL_VAL); // RL2
	assign addr_mask = addr[`GPM_MASK_HI:`GPM_MASK_LO]; // RL3
	assign clear_bits = (wr && addr == `GPM_OFF_ICLR) ? wdata[WIDTH-1:0] : {WIDTH{1'b0}}; // RL14

	// ==========================================================
	// Input synchroniser
	gpm_sync #(
		.WIDTH (WIDTH)
	) u_sync (
		.clk   (clk),
		.rst_n (rst_n),
		.din   (pin_in),
		.dout  (pin_sync)
	);

	// ==========================================================
	// Per-pin interrupt detectors
	genvar g;
	generate
		for (g = 0; g < WIDTH; g = g + 1) begin : g_pin
			gpm_irq_pin u_det (
				.clk      (clk),
				.rst_n    (rst_n),
				.level    (pin_sync[g]),
				.sense    (irq_sense_select[g]),
				.dual     (irq_dual_edge[g]),
				.polarity (irq_event_polarity[g]),
				.clear    (clear_bits[g]),
				.raw      (irq_raw_status[g]) // RL12
			);
		end
	endgenerate

	assign irq_masked_status = irq_raw_status & irq_enable_mask; // RL11 RL13

	// ==========================================================
	// Configuration registers
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_direction        <= `GPM_RST_ZERO; // RL18 RL19
			alt_function_select  <= AF_RESET; // RL18 RL19
			irq_sense_select     <= `GPM_RST_ZERO;
			irq_dual_edge        <= `GPM_RST_ZERO;
			irq_event_polarity   <= `GPM_RST_ZERO;
			irq_enable_mask      <= `GPM_RST_ZERO;
			drive_low_select     <= `GPM_RST_DRV_LOW;
			drive_mid_select     <= `GPM_RST_ZERO;
			drive_high_select    <= `GPM_RST_ZERO;
			open_drain_enable    <= `GPM_RST_ZERO;
			pull_up_enable       <= `GPM_RST_PULLUP;
			pull_down_enable     <= `GPM_RST_ZERO;
			slew_limit_enable    <= `GPM_RST_ZERO;
			digital_input_enable <= `GPM_RST_DEN;
		end else if (wr) begin
			case (addr)
				`GPM_OFF_DIR:      pin_direction        <= wdata[WIDTH-1:0];
				`GPM_OFF_SENSE:    irq_sense_select     <= wdata[WIDTH-1:0];
				`GPM_OFF_DUAL:     irq_dual_edge        <= wdata[WIDTH-1:0];
				`GPM_OFF_EVENT:    irq_event_polarity   <= wdata[WIDTH-1:0];
				`GPM_OFF_IMASK:    irq_enable_mask      <= wdata[WIDTH-1:0];
				`GPM_OFF_AFSEL:    alt_function_select  <= wdata[WIDTH-1:0];
				`GPM_OFF_DRV_LOW:  drive_low_select     <= wdata[WIDTH-1:0]; // RL21
				`GPM_OFF_DRV_MID:  drive_mid_select     <= wdata[WIDTH-1:0]; // RL21
				`GPM_OFF_DRV_HIGH: drive_high_select    <= wdata[WIDTH-1:0]; // RL21
				`GPM_OFF_ODRAIN:   open_drain_enable    <= wdata[WIDTH-1:0]; // RL21
				`GPM_OFF_PULLUP:   pull_up_enable       <= wdata[WIDTH-1:0]; // RL21
				`GPM_OFF_PULLDN:   pull_down_enable     <= wdata[WIDTH-1:0]; // RL21
				`GPM_OFF_SLEW:     slew_limit_enable    <= wdata[WIDTH-1:0]; // RL21
				`GPM_OFF_DEN:      digital_input_enable <= wdata[WIDTH-1:0]; // RL21
				default: ;
			endcase
		end
	end

	// ==========================================================
	// Port value: inputs capture pins, outputs take masked writes
	integer i;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			port_value <= `GPM_RST_ZERO;
		end else begin
			for (i = 0; i < WIDTH; i = i + 1) begin
				if (!pin_direction[i])
					port_value[i] <= pin_sync[i]; // RL1 RL22
				else if (wr && data_hit && addr_mask[i])
					port_value[i] <= wdata[i]; // RL4 RL23
			end
		end
	end

	// ==========================================================
	// Pad drive: software or alternate function
	integer k;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_out <= `GPM_RST_ZERO;
			pin_oe  <= `GPM_RST_ZERO;
			irq     <= 1'b0;
		end else begin
			for (k = 0; k < WIDTH; k = k + 1) begin
				if (alt_function_select[k]) begin
					pin_out[k] <= alt_out[k]; // RL16
					pin_oe[k]  <= alt_oe[k];
				end else begin
					pin_out[k] <= port_value[k]; // RL1 RL17
					pin_oe[k]  <= pin_direction[k];
				end
			end
			irq <= |irq_masked_status; // RL6 RL24
		end
	end

	assign alt_in = pin_sync;

	// ==========================================================
	// Read path
	always @* begin
		next_rdata = `GPM_RD_ZERO;
		if (data_hit) begin
			next_rdata[WIDTH-1:0] = port_value & addr_mask; // RL5 RL22
		end else begin
			case (addr)
				`GPM_OFF_DIR:      next_rdata[WIDTH-1:0] = pin_direction;
				`GPM_OFF_SENSE:    next_rdata[WIDTH-1:0] = irq_sense_select;
				`GPM_OFF_DUAL:     next_rdata[WIDTH-1:0] = irq_dual_edge;
				`GPM_OFF_EVENT:    next_rdata[WIDTH-1:0] = irq_event_polarity;
				`GPM_OFF_IMASK:    next_rdata[WIDTH-1:0] = irq_enable_mask;
				`GPM_OFF_RAW:      next_rdata[WIDTH-1:0] = irq_raw_status; // RL12
				`GPM_OFF_MSTAT:    next_rdata[WIDTH-1:0] = irq_masked_status; // RL13
				`GPM_OFF_AFSEL:    next_rdata[WIDTH-1:0] = alt_function_select;
				`GPM_OFF_DRV_LOW:  next_rdata[WIDTH-1:0] = drive_low_select;
				`GPM_OFF_DRV_MID:  next_rdata[WIDTH-1:0] = drive_mid_select;
				`GPM_OFF_DRV_HIGH: next_rdata[WIDTH-1:0] = drive_high_select;
				`GPM_OFF_ODRAIN:   next_rdata[WIDTH-1:0] = open_drain_enable;
				`GPM_OFF_PULLUP:   next_rdata[WIDTH-1:0] = pull_up_enable;
				`GPM_OFF_PULLDN:   next_rdata[WIDTH-1:0] = pull_down_enable;
				`GPM_OFF_SLEW:     next_rdata[WIDTH-1:0] = slew_limit_enable;
				`GPM_OFF_DEN:      next_rdata[WIDTH-1:0] = digital_input_enable;
				default:           next_rdata = `GPM_RD_ZERO;
			endcase
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			rdata <= `GPM_RD_ZERO;
		else if (rd)
			rdata <= next_rdata;
		else
			rdata <= `GPM_RD_ZERO;
	end
endmodule

// >>> gpm_map.vh
// Register map, field constants and reset values for the masked-access GPIO port
// What this block does
// (RL1) Direction 0 captures pin level into port value; 1 drives pin from it.
// (RL2) Port value register answers at 256 distinct bus addresses.
// (RL3) Address bits 9..2 form an eight-bit per-pin access mask.
// (RL4) Writes update only port value bits whose address mask bit is 1.
// (RL5) Reads return zero for bits whose address mask bit is 0.
// (RL6) All unmasked pending pin interrupts combine into one interrupt output.
// (RL7) Edge interrupts stay latched until software clears them.
// (RL8) Level sources hold their active level until the interrupt is recognised.
// (RL9) Sense bit picks edge or level; dual-edge bit picks one or both edges.
// (RL10) Event bit picks low/falling when 0, high/rising when 1.
// (RL11) Interrupt mask bit 0 blocks a pin, 1 passes it.
// (RL12) Raw status shows every triggered pin regardless of mask.
// (RL13) Masked status shows only pending pins that the mask lets through.
// (RL14) Writing 1 to a clear bit clears that pending interrupt; 0 does nothing.
// (RL15) Software masks pins before changing sense, dual-edge or event settings.
// (RL16) Alternate-function bit set gives the pin to its peripheral.
// (RL17) Alternate-function bit clear gives the pin to the port value register.
// (RL18) Reset makes pins inputs, alternate function off except JTAG pins on; here alternate function resets to AF_RESET, default 8'h00 (all off).
// (RL19) Power-on or external reset restores default pin configuration.
// (RL20) Software enables the port peripheral clock before use.
// (RL21) Port holds pull, drive, slew, open-drain and digital enable pad settings.
// (RL22) Port value reads give written value for outputs, pin level for inputs.
// (RL23) Writes affect only unmasked bits that are configured as outputs.
// (RL24) Pins synchronised before detection; interrupt is OR of masked status.
// (RL25) Level-mode raw status follows the level; clearing cannot hide it.
`ifndef GPM_MAP_VH
`define GPM_MAP_VH

// ==========================================================
// Register offsets (byte addresses, bits 11..0)
`define GPM_OFF_DATA_LO    12'h000
`define GPM_OFF_DATA_HI    12'h3FC
`define GPM_OFF_DIR        12'h400
`define GPM_OFF_SENSE      12'h404
`define GPM_OFF_DUAL       12'h408
`define GPM_OFF_EVENT      12'h40C
`define GPM_OFF_IMASK      12'h410
`define GPM_OFF_RAW        12'h414
`define GPM_OFF_MSTAT      12'h418
`define GPM_OFF_ICLR       12'h41C
`define GPM_OFF_AFSEL      12'h420
`define GPM_OFF_DRV_LOW    12'h500
`define GPM_OFF_DRV_MID    12'h504
`define GPM_OFF_DRV_HIGH   12'h508
`define GPM_OFF_ODRAIN     12'h50C
`define GPM_OFF_PULLUP     12'h510
`define GPM_OFF_PULLDN     12'h514
`define GPM_OFF_SLEW       12'h518
`define GPM_OFF_DEN        12'h51C

// ==========================================================
// Address field positions
`define GPM_ADDR_W         12
`define GPM_MASK_HI        9
`define GPM_MASK_LO        2
`define GPM_DATA_SEL_HI    11
`define GPM_DATA_SEL_LO    10
`define GPM_DATA_SEL_VAL   2'h0

// ==========================================================
// Reset values
`define GPM_RST_ZERO       8'h00
`define GPM_RST_DRV_LOW    8'hFF
`define GPM_RST_PULLUP     8'hFF
`define GPM_RST_DEN        8'hFF
`define GPM_RST_AFSEL      8'h00
`define GPM_RD_ZERO        32'h00000000

`endif

// >>> gpm_sync.v
// Two-stage synchroniser for one port's pin inputs
`timescale 1ns/1ps
module gpm_sync #(
	parameter WIDTH = 8
) (
	// Clock and reset
	input  wire             clk,
	input  wire             rst_n,
	// Data
	input  wire [WIDTH-1:0] din,
	output reg  [WIDTH-1:0] dout
);
	reg [WIDTH-1:0] stage1;

	// ==========================================================
	// Synchroniser
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stage1 <= {WIDTH{1'b0}};
			dout   <= {WIDTH{1'b0}};
		end else begin
			stage1 <= din; // RL24
			dout   <= stage1;
		end
	end
endmodule

// >>> gpm_irq_pin.v
// Interrupt detector for a single pin
`timescale 1ns/1ps
module gpm_irq_pin (
	// Clock and reset
	input  wire clk,
	input  wire rst_n,
	// Pin and configuration
	input  wire level,
	input  wire sense,
	input  wire dual,
	input  wire polarity,
	input  wire clear,
	// Status
	output reg  raw
);
	reg  prev;
	wire rise;
	wire fall;
	wire edge_hit;
	wire level_hit;

	assign rise      = level & ~prev;
	assign fall      = ~level & prev;
	assign edge_hit  = dual ? (rise | fall) : (polarity ? rise : fall); // RL9 RL10
	assign level_hit = (level == polarity); // RL10

	// ==========================================================
	// Detector
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prev <= 1'b0;
			raw  <= 1'b0;
		end else begin
			prev <= level;
			if (sense)
				raw <= level_hit; // RL25
			else if (edge_hit)
				raw <= 1'b1; // RL7
			else if (clear)
				raw <= 1'b0; // RL14
		end
	end
endmodule

// >>> gpm_pad_model.sv
// Pad model: a driven pad reads back its own level, otherwise the outside level
`timescale 1ns/1ps
module gpm_pad_model (
	// Port side
	input  wire [7:0] pin_out,
	input  wire [7:0] pin_oe,
	// Outside world, held steady by the bench until seen
	input  wire [7:0] ext_level,
	output wire [7:0] pin_in
);
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule

// >>> gpm_port_asserts.sv
// Checker on the ports of the GPIO port
`timescale 1ns/1ps
`include "gpm_map.vh"
module gpm_port_asserts (
	input wire        clk,
	input wire        rst_n,
	input wire [11:0] addr,
	input wire [31:0] wdata,
	input wire        wr,
	input wire        rd,
	input wire [31:0] rdata,
	input wire [7:0]  pin_in,
	input wire [7:0]  alt_in,
	input wire [63:0] pads,
	input wire [7:0]  pull_up_enable,
	input wire        irq
);
	reg [1:0] cnt;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	always @(posedge clk or negedge rst_n)
		if (!rst_n) cnt <= 2'h0;
		else if (cnt != 2'h3) cnt <= cnt + 2'h1;
	a_read_mask: assert property (rd && addr[11:10] == 2'h0 |=>
		(rdata[7:0] & ~$past(addr[9:2])) == 8'h00) else $error("masked bit read nonzero");
	a_rdata_idle: assert property (rdata != 32'h0 |-> $past(rd))
		else $error("read data outside read slot");
	a_rdata_upper: assert property (rdata[31:8] == 24'h0)
		else $error("upper read bits nonzero");
	a_unmapped_rd: assert property (rd && addr == 12'h600 |=> rdata == 32'h0)
		else $error("unmapped read nonzero");
	a_clear_wo: assert property (rd && addr == `GPM_OFF_ICLR |=> rdata == 32'h0)
		else $error("clear register readable");
	a_pad_hold: assert property ($changed(pads) |-> $past(wr) && $past(addr[11:8]) == 4'h5)
		else $error("pad setting changed without write");
	a_pullup_wr: assert property (wr && addr == `GPM_OFF_PULLUP |=>
		pull_up_enable == $past(wdata[7:0])) else $error("pull-up write lost");
	a_alt_sync: assert property (cnt == 2'h3 |-> alt_in == $past(pin_in, 2))
		else $error("pin sync latency wrong");
	c_irq: cover property ($rose(irq));
	c_clear: cover property (wr && addr == `GPM_OFF_ICLR);
	c_mask_rd: cover property (rd && addr[11:10] == 2'h0 && addr[9:2] != 8'hFF);
endmodule
bind gpm_port gpm_port_asserts u_chk (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
	.wr(wr), .rd(rd), .rdata(rdata), .pin_in(pin_in), .alt_in(alt_in), .irq(irq),
	.pull_up_enable(pull_up_enable), .pads({digital_input_enable, slew_limit_enable,
	pull_down_enable, pull_up_enable, open_drain_enable, drive_high_select,
	drive_mid_select, drive_low_select}));

// >>> test_gpm_port.sv
// Self-checking bench for the GPIO port
`timescale 1ns/1ps
`include "gpm_map.vh"
module test_gpm_port;
	reg         clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
	reg  [11:0] addr = 12'h0;
	reg  [31:0] wdata = 32'h0;
	reg  [7:0]  ext = 8'h00, alt_out = 8'h00, alt_oe = 8'h00;
	wire [7:0]  pin_in, pin_out, pin_oe, alt_in, dl, dm, dh, od, pu, pd, sl, de;
	wire [31:0] rdata;
	wire        irq;
	wire [63:0] pads = {de, sl, pd, pu, od, dh, dm, dl};
	integer     mismatches = 0, n_compared = 0, cyc = 0, i;
	always #10 clk = ~clk;
	gpm_port u_dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .alt_out(alt_out),
		.alt_oe(alt_oe), .alt_in(alt_in), .drive_low_select(dl), .drive_mid_select(dm),
		.drive_high_select(dh), .open_drain_enable(od), .pull_up_enable(pu),
		.pull_down_enable(pd), .slew_limit_enable(sl), .digital_input_enable(de), .irq(irq));
	gpm_pad_model u_pad (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext), .pin_in(pin_in));
	task chk(input string nm, input [63:0] e, input [63:0] g);
		n_compared = n_compared + 1;
		if (g !== e) begin
			mismatches = mismatches + 1;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task bus_wr(input [11:0] a, input [7:0] d);
		@(posedge clk) begin addr <= a; wdata <= {24'h0, d}; wr <= 1'b1; end
		@(posedge clk) wr <= 1'b0;
	endtask
	task bus_rd(input [11:0] a, input [31:0] e);
		@(posedge clk) begin addr <= a; rd <= 1'b1; end
		@(posedge clk) rd <= 1'b0;
		#1 chk("rdata", {32'h0, e}, {32'h0, rdata});
	endtask
	task t_reset;
		chk("pads", 64'hFF0000FF000000FF, pads);
		chk("pin_oe", 64'h0, {56'h0, pin_oe});
		bus_rd(`GPM_OFF_DIR, 32'h0);
		bus_rd(`GPM_OFF_AFSEL, 32'h0);
	endtask
	task t_pad;
		for (i = 0; i < 8; i = i + 1) begin
			bus_wr(12'h500 + 12'(4 * i), 8'(8'h3C ^ i));
			#1 chk("pad", {56'h0, 8'(8'h3C ^ i)}, {56'h0, pads[i*8+:8]});
		end
	endtask
	task t_mask;
		bus_wr(`GPM_OFF_DIR, 8'hFF);
		bus_wr(`GPM_OFF_DATA_HI, 8'h00);
		bus_wr(12'h098, 8'hEB);
		bus_rd(`GPM_OFF_DATA_HI, 32'h22);
		bus_rd(12'h0C4, 32'h20);
		chk("pin_out", 64'h22, {56'h0, pin_out});
	endtask
	task t_input;
		bus_wr(`GPM_OFF_DIR, 8'h0F);
		ext <= 8'hA5;
		repeat (4) @(posedge clk);
		bus_rd(`GPM_OFF_DATA_HI, 32'hA2);
		bus_wr(`GPM_OFF_DATA_HI, 8'hFF);
		repeat (4) @(posedge clk);
		bus_rd(`GPM_OFF_DATA_HI, 32'hAF);
		bus_rd(12'h600, 32'h0);
	endtask
	task t_alt;
		alt_oe <= 8'h01;
		bus_wr(`GPM_OFF_AFSEL, 8'h01);
		repeat (2) @(posedge clk);
		chk("alt", 64'h2, {62'h0, pin_oe[0], pin_out[0]});
		bus_wr(`GPM_OFF_AFSEL, 8'h00);
		repeat (2) @(posedge clk);
		chk("gpio", 64'h3, {62'h0, pin_oe[0], pin_out[0]});
	endtask
	task t_edge;
		ext <= 8'h00;
		bus_wr(`GPM_OFF_DIR, 8'h00);
		bus_wr(`GPM_OFF_EVENT, 8'h04);
		repeat (5) @(posedge clk);
		bus_wr(`GPM_OFF_ICLR, 8'hFF);
		bus_rd(`GPM_OFF_ICLR, 32'h0);
		bus_rd(`GPM_OFF_RAW, 32'h00);
		ext <= 8'h04;
		repeat (5) @(posedge clk);
		bus_rd(`GPM_OFF_RAW, 32'h04);
		bus_rd(`GPM_OFF_MSTAT, 32'h00);
		chk("irq", 64'h0, {63'h0, irq});
		bus_wr(`GPM_OFF_IMASK, 8'h04);
		repeat (3) @(posedge clk);
		chk("irq", 64'h1, {63'h0, irq});
		ext <= 8'h00;
		repeat (5) @(posedge clk);
		bus_wr(`GPM_OFF_ICLR, 8'h00);
		bus_rd(`GPM_OFF_RAW, 32'h04);
		bus_wr(`GPM_OFF_ICLR, 8'h04);
		bus_rd(`GPM_OFF_RAW, 32'h00);
		repeat (2) @(posedge clk);
		chk("irq", 64'h0, {63'h0, irq});
	endtask
	task t_dual_level;
		bus_wr(`GPM_OFF_IMASK, 8'h00);
		bus_wr(`GPM_OFF_DUAL, 8'h08);
		bus_wr(`GPM_OFF_ICLR, 8'hFF);
		ext <= 8'h18;
		repeat (5) @(posedge clk);
		bus_wr(`GPM_OFF_ICLR, 8'hFF);
		ext <= 8'h10;
		repeat (5) @(posedge clk);
		bus_rd(`GPM_OFF_RAW, 32'h08);
		bus_wr(`GPM_OFF_SENSE, 8'h10);
		bus_wr(`GPM_OFF_DUAL, 8'h00);
		ext <= 8'h00;
		bus_wr(`GPM_OFF_ICLR, 8'hFF);
		repeat (3) @(posedge clk);
		bus_rd(`GPM_OFF_RAW, 32'h10);
		bus_wr(`GPM_OFF_ICLR, 8'h10);
		bus_rd(`GPM_OFF_RAW, 32'h10);
		ext <= 8'h10;
		repeat (5) @(posedge clk);
		bus_rd(`GPM_OFF_RAW, 32'h00);
	endtask
	task t_reset2;
		@(posedge clk) rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		#1 chk("pads", 64'hFF0000FF000000FF, pads);
		chk("pin_oe", 64'h0, {56'h0, pin_oe});
	endtask
	task complete_run;
		$display("mismatches %0d n_compared %0d", mismatches, n_compared);
		if (mismatches == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			mismatches = mismatches + 1;
			complete_run;
		end
	end
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		#1 t_reset;
		t_pad;
		t_mask;
		t_input;
		t_alt;
		t_edge;
		t_dual_level;
		t_reset2;
		complete_run;
	end
endmodule
